// ---- testbench/tcc_far_model.sv ----
`timescale 1ns/1ps
// ****************************************************************
// counter block and capture pin seen from the channel
// ****************************************************************
module tcc_far_model (
  input  wire logic                 clk,
  input  wire logic                 srst,
  input  wire logic                 run,
  input  wire logic                 load,
  input  wire logic [15:0]          load_val,
  input  wire logic [15:0]          max_val,
  input  wire logic                 pin_lvl,
  input  wire logic                 reset_req,
  output tcc_pkg::tcc_cnt_type      cnt,
  output logic                      capture_input_pin
);
  import tcc_pkg::*;
  logic [15:0] value_q;
  // up count only; the pulses stand in the cycle before the counter moves
  always_comb begin
    cnt.value   = value_q;
    cnt.step    = run;
    cnt.at_max  = run & (value_q == max_val);
    cnt.at_zero = run & (value_q == 16'h0000);
    cnt.wrap    = run & (value_q == max_val);
    cnt.mode    = TCC_UP;
  end
  assign capture_input_pin = pin_lvl;
  always_ff @(posedge clk) begin
    if (srst) begin
      value_q <= 16'h0000;
    end else if (load) begin
      value_q <= load_val;
    end else if (reset_req) begin
      value_q <= 16'h0000;
    end else if (run) begin
      value_q <= (value_q == max_val) ? 16'h0000 : value_q + 16'h0001;
    end
  end
endmodule

// ---- testbench/timer_compare_capture_channel_test.sv ----
`timescale 1ns/1ps
module timer_compare_capture_channel_test;
  import tcc_pkg::*;
  localparam logic [7:0] E1 = 8'h5E;
  localparam logic [7:0] E2 = 8'hD2;
  logic clk, srst, pin, pmatch, run, load, hit, rd_seen;
  logic match, cap_ev, crr, tos;
  logic [15:0] rdata, flags, irq_req, load_val, lf, exp;
  logic [15:0] match_cnt, cap_cnt;
  tcc_bus_type bus;
  tcc_cnt_type cnt;
  logic [15:0] exp_q[$];
  int bad_count, num_checks;
  tcc_channel tcc_channel_i (.clk(clk), .srst(srst), .bus(bus), .rdata(rdata), .cnt(cnt),
    .capture_input_pin(pin), .partner_match(pmatch), .irq_flags(flags), .irq_req(irq_req),
    .match(match), .capture_event(cap_ev), .counter_reset_req(crr), .timer_output_signal(tos));
  tcc_far_model tcc_far_model_i (.clk(clk), .srst(srst), .run(run), .load(load),
    .load_val(load_val), .max_val(16'h000F), .pin_lvl(pin), .reset_req(crr), .cnt(cnt),
    .capture_input_pin());
  // ****************************************************************
  // helpers
  // ****************************************************************
  always #5 clk = ~clk;
  function automatic logic [15:0] nx(input logic [15:0] x);
    return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
  endfunction
  function automatic logic [15:0] cc(input logic [2:0] cb, input logic [1:0] src,
    input logic [1:0] eg, input logic [2:0] wv, input logic sft, input logic inv,
    input logic cap, input logic sync_capture_select, input logic par);
    return {sync_capture_select, cb, src, eg, 1'b0, par, sft, wv, inv, cap};
  endfunction
  task automatic check(input logic [15:0] seen, input logic [15:0] want);
    num_checks++;
    if (seen !== want) begin
      bad_count++;
      $display("mismatch at %0t: saw %h expected %h", $time, seen, want);
    end
  endtask
  task automatic ckout(input logic want);
    check({15'h0000, tos}, {15'h0000, want});
  endtask
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge clk);
    bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clk);
    bus.wr <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, input logic [15:0] e);
    @(posedge clk);
    bus <= '{addr: a, wdata: 16'h0000, wr: 1'b0, rd: 1'b1};
    exp_q.push_back(e);
    @(posedge clk);
    bus.rd <= 1'b0;
  endtask
  task automatic load_cnt(input logic [15:0] v);
    @(posedge clk);
    load <= 1'b1;
    load_val <= v;
    @(posedge clk);
    load <= 1'b0;
  endtask
  // stops one count past the target; reports whether it was reached
  task automatic run_to(input logic [15:0] t, input int lim, output logic got);
    int n;
    n = 0;
    @(posedge clk);
    run <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (cnt.value !== t && n < lim);
    got = (cnt.value === t);
    run <= 1'b0;
    @(posedge clk);
  endtask
  always @(posedge clk) begin
    if (rd_seen) check(rdata, exp_q.pop_front());
    rd_seen <= bus.rd;
    // pulse counters so the match and capture outputs are looked at too
    if (!srst) begin
      match_cnt <= match_cnt + {15'h0000, match};
      cap_cnt   <= cap_cnt + {15'h0000, cap_ev};
    end
  end
  initial begin
    #100000;
    bad_count++;
    tally_and_finish();
  end
  // ****************************************************************
  // scenarios
  // ****************************************************************
  initial begin
    {clk, pin, pmatch, run, load, rd_seen} = '0;
    {match_cnt, cap_cnt} = '0;
    srst = 1'b1;
    bus = '0;
    flags = 16'h0000;
    load_val = 16'h0000;
    lf = 16'h005C;
    repeat (8) @(posedge clk);
    srst <= 1'b0;
    rd(ADDR_CTRL, CTRL_RESET);
    rd(ADDR_DATA, DATA_RESET);
    rd(ADDR_IRQ_EN, IRQ_EN_RESET);
    wr(ADDR_CTRL, 16'hFFFF);
    rd(ADDR_CTRL, CTRL_WMASK);
    wr(ADDR_CTRL, 16'h0000);
    wr(4'h6, 16'hFFFF);
    rd(4'h6, 16'h0000);
    // flags are still clear when the enables go up
    wr(ADDR_IRQ_EN, 16'hFFFF);
    rd(ADDR_IRQ_EN, IRQ_IMPL_MASK);
    repeat (3) begin
      lf = nx(lf);
      @(posedge clk);
      flags <= lf;
      @(posedge clk);
      check(irq_req, lf & IRQ_IMPL_MASK);
    end
    wr(ADDR_IRQ_EN, 16'h0000);
    @(posedge clk);
    check(irq_req, 16'h0000);
    lf = nx(lf);
    exp = lf;
    wr(ADDR_DATA, lf);
    rd(ADDR_DATA, exp);
    // frozen counter, so the captured value is known exactly
    for (int s = 0; s < 2; s++) begin
      for (int e = 0; e < 4; e++) begin
        // rise-only runs asynchronous, fall and both run synchronous
        wr(ADDR_CTRL, cc(3'h0, s ? SRC_SOFT_LOW : SRC_PIN, e[1:0], 3'h0, 1'b0, 1'b0, 1'b1, e[1], 1'b0));
        for (int ph = 0; ph < 2; ph++) begin
          lf = nx(lf);
          load_cnt(lf);
          if (e[ph]) exp = lf;
          if (s) wr(ADDR_CTRL, cc(3'h0, ph ? SRC_SOFT_LOW : SRC_SOFT_HIGH, e[1:0], 3'h0, 1'b0, 1'b0,
            1'b1, e[1], 1'b0));
          else begin
            @(posedge clk);
            pin <= !ph;
          end
          repeat (3) @(posedge clk);
          rd(ADDR_DATA, exp);
        end
      end
    end
    wr(ADDR_CTRL, cc(CBUF_ON_WRITE, 2'h0, 2'h0, WAVE_SOFT, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0));
    wr(ADDR_DATA, 16'h0005);
    for (int w = 1; w < 8; w++) begin
      load_cnt(16'h0000);
      wr(ADDR_CTRL, cc(CBUF_ON_WRITE, 2'h0, 2'h0, WAVE_SOFT, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0));
      wr(ADDR_CTRL, cc(CBUF_ON_WRITE, 2'h0, 2'h0, w[2:0], 1'b0, 1'b0, 1'b0, 1'b0, 1'b0));
      run_to(16'h0008, 64, hit);
      ckout(E1[w]);
      run_to(16'h0002, 64, hit);
      ckout(E2[w]);
    end
    for (int k = 0; k < 4; k++) begin
      wr(ADDR_CTRL, cc(3'h0, 2'h0, 2'h0, WAVE_SOFT, k[0], k[1], 1'b0, 1'b0, 1'b0));
      repeat (2) @(posedge clk);
      ckout(k[0] ^ k[1]);
    end
    for (int p = 0; p < 2; p++) begin
      wr(ADDR_CTRL, cc(3'h0, 2'h0, 2'h0, WAVE_SOFT, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0));
      wr(ADDR_CTRL, cc(3'h0, 2'h0, 2'h0, WAVE_SET, 1'b0, 1'b0, 1'b0, 1'b0, p[0]));
      @(posedge clk);
      pmatch <= 1'b1;
      @(posedge clk);
      pmatch <= 1'b0;
      repeat (2) @(posedge clk);
      ckout(p[0]);
    end
    // the old value must still match until the counter end
    wr(ADDR_CTRL, cc(3'h0, 2'h0, 2'h0, WAVE_SOFT, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0));
    wr(ADDR_CTRL, cc(CBUF_ON_END, 2'h0, 2'h0, WAVE_TGL, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0));
    wr(ADDR_DATA, 16'h000A);
    run_to(16'h0008, 64, hit);
    ckout(1'b1);
    run_to(16'h0002, 64, hit);
    run_to(16'h000C, 64, hit);
    ckout(1'b0);
    // seven waveform passes plus two here; eight captures in the capture loop
    check(match_cnt, 16'h0009);
    check(cap_cnt, 16'h0008);
    wr(ADDR_CTRL, cc(CBUF_MATCH_RST, 2'h0, 2'h0, WAVE_TGL, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0));
    run_to(16'h0002, 64, hit);
    run_to(16'h000C, 40, hit);
    check({15'h0000, hit}, 16'h0000);
    repeat (4) @(posedge clk);
    tally_and_finish();
  end
endmodule

// ---- verilog/tcc_channel.sv ----
`timescale 1ns/1ps
// Overview of operation
// - enable bit passes interrupt; unimplemented bits read 0
// - sync select: synchronous or asynchronous capture
// - load mode 0: buffer loads after write
// - load mode 1: load at max/zero end
// - load mode 2: load on previous-value match
// - load mode 3: load on counter wrap; on match or zero in up/down
// - load mode 4: match loads, counter resets
// - trigger source: pin or software level
// - edge select: rise, fall, both, none
// - software level change 2/3 captures
// - paired select uses pair matches
// - soft level bit drives output directly
// - mode 7: match resets, end sets
// - mode 6: match toggles, end sets
// - mode 5: match resets output
// - mode 4: match toggles output
// - mode 3: match sets, end resets
// - mode 2: match toggles, end resets
// - mode 1: match sets output
// - mode 0: output follows soft level
// - capture select: capture or compare mode
// - invert bit makes output active low
// - data register: compare value or capture
module tcc_channel (
  input  wire logic                 clk,
  input  wire logic                 srst,
  input  wire tcc_pkg::tcc_bus_type bus,
  output logic [15:0]               rdata,
  input  wire tcc_pkg::tcc_cnt_type cnt,
  input  wire logic                 capture_input_pin,
  input  wire logic                 partner_match,
  input  wire logic [15:0]          irq_flags,
  output logic [15:0]               irq_req,
  output logic                      match,
  output logic                      capture_event,
  output logic                      counter_reset_req,
  output logic                      timer_output_signal
);
  import tcc_pkg::*;

  tcc_state_type s_q;
  tcc_state_type s_d;

  logic        cap_mode;
  logic        sync_sel;
  logic [2:0]  cbuf_mode;
  logic [1:0]  src_sel;
  logic [1:0]  edge_sel;
  logic        paired;
  logic [2:0]  wave_mode;
  logic        wr_ctrl;
  logic        wr_data;
  logic [1:0]  new_src;
  logic        rise_now;
  logic        fall_now;
  logic        rise_use;
  logic        fall_use;
  logic        cap_fire;
  logic        buf_load;
  logic        end_evt;
  logic        set_evt;
  logic        rst_evt;
  logic        tgl_evt;
  logic        pair_hit;

  assign cap_mode  = s_q.ctrl[POS_CAPMODE];
  assign sync_sel  = s_q.ctrl[POS_SCS];
  assign cbuf_mode = s_q.ctrl[POS_CBUF+:3];
  assign src_sel   = s_q.ctrl[POS_SRC+:2];
  assign edge_sel  = s_q.ctrl[POS_EDGE+:2];
  assign paired    = s_q.ctrl[POS_PAIRED];
  assign wave_mode = s_q.ctrl[POS_WMODE+:3];
  assign wr_ctrl   = bus.wr && (bus.addr == ADDR_CTRL);
  assign wr_data   = bus.wr && (bus.addr == ADDR_DATA);
  assign new_src   = bus.wdata[POS_SRC+:2];

  // ****************************************************************
  // comparator
  // ****************************************************************
  // the match is taken against the buffered value, never the freshly written one
  assign match = !cap_mode && cnt.step && (cnt.value == s_q.cbuf);
  assign counter_reset_req = match && (cbuf_mode == CBUF_MATCH_RST);

  // counter end event: max when counting up or up/down, zero when counting down
  assign end_evt  = (cnt.mode == TCC_DOWN) ? cnt.at_zero : cnt.at_max;
  assign pair_hit = match || partner_match;

  always_comb begin
    buf_load = 1'b0;
    case (cbuf_mode)
      CBUF_ON_WRITE: buf_load = s_q.load_pend;
      CBUF_ON_END: begin
        if (cnt.mode == TCC_UPDOWN) begin
          buf_load = cnt.at_zero || cnt.at_max;
        end else begin
          buf_load = end_evt;
        end
      end
      CBUF_ON_MATCH: buf_load = match;
      CBUF_ON_WRAP: begin
        if (cnt.mode == TCC_UPDOWN) begin
          buf_load = match || cnt.at_zero;
        end else begin
          buf_load = cnt.wrap;
        end
      end
      CBUF_MATCH_RST: buf_load = match;
      default: buf_load = 1'b0;
    endcase
    buf_load = buf_load && !cap_mode;
  end

  // ****************************************************************
  // capture trigger
  // ****************************************************************
  always_comb begin
    rise_now = 1'b0;
    fall_now = 1'b0;
    if (src_sel == SRC_PIN) begin
      rise_now = capture_input_pin && !s_q.pin;
      fall_now = !capture_input_pin && s_q.pin;
    end else if (wr_ctrl && (src_sel == SRC_SOFT_LOW) && (new_src == SRC_SOFT_HIGH)) begin
      rise_now = 1'b1;
    end else if (wr_ctrl && (src_sel == SRC_SOFT_HIGH) && (new_src == SRC_SOFT_LOW)) begin
      fall_now = 1'b1;
    end
    // synchronous capture costs one cycle of latency: the edge registered in the previous cycle fires it
    rise_use = sync_sel ? s_q.rise_dly : rise_now;
    fall_use = sync_sel ? s_q.fall_dly : fall_now;
    cap_fire = 1'b0;
    case (edge_sel)
      EDGE_RISE: cap_fire = rise_use;
      EDGE_FALL: cap_fire = fall_use;
      EDGE_BOTH: cap_fire = rise_use || fall_use;
      default:   cap_fire = 1'b0;
    endcase
    cap_fire = cap_fire && cap_mode;
  end
  assign capture_event = cap_fire;

  // ****************************************************************
  // output waveform events
  // ****************************************************************
  always_comb begin
    set_evt = 1'b0;
    rst_evt = 1'b0;
    tgl_evt = 1'b0;
    case (wave_mode)
      WAVE_RST_SET: begin
        rst_evt = match;
        set_evt = paired ? partner_match : end_evt;
      end
      WAVE_TGL_SET: begin
        tgl_evt = match;
        set_evt = paired ? partner_match : end_evt;
      end
      WAVE_RST: rst_evt = paired ? pair_hit : match;
      WAVE_TGL: tgl_evt = paired ? pair_hit : match;
      WAVE_SET_RST: begin
        set_evt = match;
        rst_evt = paired ? partner_match : end_evt;
      end
      WAVE_TGL_RST: begin
        tgl_evt = match;
        rst_evt = paired ? partner_match : end_evt;
      end
      WAVE_SET: set_evt = paired ? pair_hit : match;
      default: begin
        set_evt = 1'b0;
        rst_evt = 1'b0;
        tgl_evt = 1'b0;
      end
    endcase
  end

  // ****************************************************************
  // next state
  // ****************************************************************
  always_comb begin
    s_d           = s_q;
    s_d.pin       = capture_input_pin;
    s_d.rise_dly  = rise_now;
    s_d.fall_dly  = fall_now;
    s_d.load_pend = 1'b0;
    s_d.rdata     = RDATA_RESET;
    if (wr_ctrl) begin
      s_d.ctrl = bus.wdata & CTRL_WMASK;
    end
    if (wr_data) begin
      s_d.data      = bus.wdata;
      s_d.load_pend = !cap_mode;
    end
    if (bus.wr && (bus.addr == ADDR_IRQ_EN)) begin
      s_d.irq_en = bus.wdata & IRQ_IMPL_MASK;
    end
    // a capture in the same cycle as a software write wins
    if (cap_fire) begin
      s_d.data = cnt.value;
    end
    if (buf_load) begin
      s_d.cbuf = s_q.data;
    end
    if (!cap_mode) begin
      if (wave_mode == WAVE_SOFT) begin
        s_d.wave = s_q.ctrl[POS_SOFT];
      end else if (rst_evt && (wave_mode != WAVE_SET_RST)) begin
        // outside mode 3 a reset wins over set and toggle, so in mode 2 the end or partner reset beats the match toggle
        s_d.wave = 1'b0;
      end else if (set_evt) begin
        s_d.wave = 1'b1;
      end else if (rst_evt) begin
        s_d.wave = 1'b0;
      end else if (tgl_evt) begin
        s_d.wave = !s_q.wave;
      end
      if ((wave_mode == WAVE_SET_RST) && match) begin
        s_d.wave = 1'b1;
      end
    end
    if (bus.rd) begin
      if (bus.addr == ADDR_CTRL) begin
        s_d.rdata = s_q.ctrl;
      end else if (bus.addr == ADDR_DATA) begin
        s_d.rdata = s_q.data;
      end else if (bus.addr == ADDR_IRQ_EN) begin
        s_d.rdata = s_q.irq_en;
      end else begin
        s_d.rdata = RDATA_RESET;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      s_q.ctrl      <= CTRL_RESET;
      s_q.data      <= DATA_RESET;
      s_q.cbuf      <= DATA_RESET;
      s_q.irq_en    <= IRQ_EN_RESET;
      s_q.pin       <= 1'b0;
      s_q.rise_dly  <= 1'b0;
      s_q.fall_dly  <= 1'b0;
      s_q.load_pend <= 1'b0;
      s_q.wave      <= 1'b0;
      s_q.rdata     <= RDATA_RESET;
    end else begin
      s_q <= s_d;
    end
  end

  // ****************************************************************
  // outputs
  // ****************************************************************
  assign rdata = s_q.rdata;
  // software is expected to clear a stale flag before enabling it
  assign irq_req = irq_flags & s_q.irq_en & IRQ_IMPL_MASK;
  // in capture mode the output rests low whatever the polarity
  assign timer_output_signal = cap_mode ? 1'b0 : (s_q.wave ^ s_q.ctrl[POS_INV]);

  // ****************************************************************
  // assertions
  // ****************************************************************
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (srst);

  a_irq_gate: assert property (
    irq_req == (irq_flags & s_q.irq_en) && (s_q.irq_en & ~IRQ_IMPL_MASK) == 16'h0000
  ) else $error("interrupt enable gating wrong");

  a_mode0_load: assert property (
    (wr_data && !cap_mode && cbuf_mode == CBUF_ON_WRITE && !wr_ctrl) ##1 (!wr_data && !wr_ctrl)
      |=> s_q.cbuf == $past(bus.wdata, 2)
  ) else $error("compare buffer not loaded after write");

  a_mode1_load: assert property (
    (!cap_mode && cbuf_mode == CBUF_ON_END && cnt.mode == TCC_UP && cnt.at_max)
      |=> s_q.cbuf == $past(s_q.data)
  ) else $error("compare buffer not loaded at max");

  a_mode2_load: assert property (
    (cbuf_mode == CBUF_ON_MATCH && match) |=> s_q.cbuf == $past(s_q.data)
  ) else $error("compare buffer not loaded on match");

  a_match_reset: assert property (
    (!cap_mode && cnt.step && cnt.value == s_q.cbuf && cbuf_mode == CBUF_MATCH_RST) |-> counter_reset_req
  ) else $error("counter reset request missing");

  a_async_capture: assert property (
    (cap_mode && !sync_sel && src_sel == SRC_PIN && edge_sel == EDGE_RISE && capture_input_pin && !s_q.pin)
      |=> s_q.data == $past(cnt.value)
  ) else $error("asynchronous capture missed");

  a_sync_capture: assert property (
    (cap_mode && sync_sel && !wr_ctrl && src_sel == SRC_PIN && edge_sel == EDGE_BOTH && capture_input_pin != s_q.pin)
      |=> capture_event
  ) else $error("synchronous capture not one cycle late");

  a_soft_capture: assert property (
    (cap_mode && !sync_sel && edge_sel == EDGE_RISE && src_sel == SRC_SOFT_LOW && wr_ctrl && new_src == SRC_SOFT_HIGH)
      |-> capture_event
  ) else $error("software trigger capture missed");

  a_soft_level: assert property (
    (!cap_mode && wave_mode == WAVE_SOFT && !wr_ctrl)
      |=> timer_output_signal == (s_q.ctrl[POS_SOFT] ^ s_q.ctrl[POS_INV])
  ) else $error("software output level not followed");

  a_reset_on_match: assert property (
    (wave_mode == WAVE_RST_SET && match && !wr_ctrl) |=> !s_q.wave
  ) else $error("reset/set output not cleared on match");

  a_toggle_match: assert property (
    (wave_mode == WAVE_TGL && !paired && match && !wr_ctrl) |=> s_q.wave != $past(s_q.wave)
  ) else $error("toggle output not inverted");

  a_read_latency: assert property (
    (bus.rd && bus.addr == ADDR_CTRL) |=> rdata == $past(s_q.ctrl)
  ) else $error("control read data wrong");

  c_capture: cover property (capture_event ##1 s_q.data == $past(cnt.value));
  c_match_reset: cover property (counter_reset_req);
  c_paired_toggle: cover property (paired && wave_mode == WAVE_TGL && partner_match);
  c_soft_trigger: cover property (wr_ctrl && src_sel == SRC_SOFT_HIGH && new_src == SRC_SOFT_LOW);

endmodule

// ---- verilog/tcc_pkg.sv ----
package tcc_pkg;

  // ****************************************************************
  // register map and field layout
  // ****************************************************************
  localparam logic [3:0]  ADDR_CTRL      = 4'h0;
  localparam logic [3:0]  ADDR_DATA      = 4'h2;
  localparam logic [3:0]  ADDR_IRQ_EN    = 4'h4;

  localparam int          POS_SCS        = 15;
  localparam int          POS_CBUF       = 12;
  localparam int          POS_SRC        = 10;
  localparam int          POS_EDGE       = 8;
  localparam int          POS_PAIRED     = 6;
  localparam int          POS_SOFT       = 5;
  localparam int          POS_WMODE      = 2;
  localparam int          POS_INV        = 1;
  localparam int          POS_CAPMODE    = 0;

  localparam logic [15:0] CTRL_RESET     = 16'h0000;
  localparam logic [15:0] CTRL_WMASK     = 16'hFF7F;
  localparam logic [15:0] DATA_RESET     = 16'h0000;
  localparam logic [15:0] IRQ_EN_RESET   = 16'h0000;
  // counter max/zero plus the enables of compare/capture circuits 0 to 3
  localparam logic [15:0] IRQ_IMPL_MASK  = 16'h003F;
  localparam logic [15:0] RDATA_RESET    = 16'h0000;

  // ****************************************************************
  // field encodings
  // ****************************************************************
  localparam logic [2:0]  CBUF_ON_WRITE  = 3'h0;
  localparam logic [2:0]  CBUF_ON_END    = 3'h1;
  localparam logic [2:0]  CBUF_ON_MATCH  = 3'h2;
  localparam logic [2:0]  CBUF_ON_WRAP   = 3'h3;
  localparam logic [2:0]  CBUF_MATCH_RST = 3'h4;

  localparam logic [1:0]  SRC_PIN        = 2'h0;
  localparam logic [1:0]  SRC_SOFT_LOW   = 2'h2;
  localparam logic [1:0]  SRC_SOFT_HIGH  = 2'h3;

  localparam logic [1:0]  EDGE_RISE      = 2'h1;
  localparam logic [1:0]  EDGE_FALL      = 2'h2;
  localparam logic [1:0]  EDGE_BOTH      = 2'h3;

  localparam logic [2:0]  WAVE_SOFT      = 3'h0;
  localparam logic [2:0]  WAVE_SET       = 3'h1;
  localparam logic [2:0]  WAVE_TGL_RST   = 3'h2;
  localparam logic [2:0]  WAVE_SET_RST   = 3'h3;
  localparam logic [2:0]  WAVE_TGL       = 3'h4;
  localparam logic [2:0]  WAVE_RST       = 3'h5;
  localparam logic [2:0]  WAVE_TGL_SET   = 3'h6;
  localparam logic [2:0]  WAVE_RST_SET   = 3'h7;

  // ****************************************************************
  // carriers
  // ****************************************************************
  typedef enum logic [1:0] {
    TCC_UP,
    TCC_DOWN,
    TCC_UPDOWN
  } tcc_cnt_mode_type;

  typedef struct packed {
    logic [15:0]      value;
    logic             step;
    logic             at_max;
    logic             at_zero;
    logic             wrap;
    tcc_cnt_mode_type mode;
  } tcc_cnt_type;

  typedef struct packed {
    logic [3:0]  addr;
    logic [15:0] wdata;
    logic        wr;
    logic        rd;
  } tcc_bus_type;

  typedef struct packed {
    logic [15:0] ctrl;
    logic [15:0] data;
    logic [15:0] cbuf;
    logic [15:0] irq_en;
    logic        pin;
    logic        rise_dly;
    logic        fall_dly;
    logic        load_pend;
    logic        wave;
    logic [15:0] rdata;
  } tcc_state_type;

endpackage
